/* shared/cim_pkg.sv */
/*
  Constants, register map and checksum helpers for the configuration integrity monitor.
  Assumes a 32-bit AXI4-Lite bus whose byte address is four times the register index.
*/
//------------------------------------------------------------------------------
// Overview of operation
// - Section zero is never checksummed.
// - Enabled sections 1-3 continuously checksummed, compared.
// - Mismatch drives section fault low, nothing else.
// - Bits run first register MSB to last LSB.
// - Polynomial select bit picks CCITT or ANSI.
// - Every pass starts from all-ones seed.
// - Sections cover 40h-59h, 80h-A3h, C0h-E3h.
// - One register bit per oscillator period.
// - Writing one clears a section fault flag.
// - Always-on trim memory checksum, fault low.
// - One trim word per oscillator period.
// - Output pins read back through separate receiver.
// - Index FFh or above raises access fault.
// - Undefined indices below FFh raise nothing.
// - Nonexistent register reads data and index zero.
// - Each monitor owns an active-low fault flag.
// - Reset and access flags in primary status.
// - Primary status drives the frame status word.
// - Combined flag low when detailed flag low.
// - Checksum engines step on diagnostic oscillator.
//------------------------------------------------------------------------------
package cim_pkg;
   localparam int          IDX_W         = 10;
   localparam int          SECTIONS      = 3;
   localparam int          CFG_WORDS     = 192;
   localparam int          TRIM_WORDS    = 16;
   localparam int          FLAG_W        = 4;
   //---------------------------------------------------------------------------
   // Register indices
   //---------------------------------------------------------------------------
   localparam logic [9:0]  IDX_PRIMARY   = 10'h000;
   localparam logic [9:0]  IDX_DIGITAL   = 10'h001;
   localparam logic [9:0]  IDX_SUPPLY    = 10'h002;
   localparam logic [9:0]  IDX_CLOCK     = 10'h003;
   localparam logic [9:0]  IDX_CONTROL   = 10'h004;
   localparam logic [9:0]  IDX_EXPECT    = 10'h005;
   localparam logic [9:0]  IDX_GPIO_CTL  = 10'h008;
   localparam logic [9:0]  IDX_GPIO_RB   = 10'h009;
   localparam logic [9:0]  IDX_TRIM_BASE = 10'h020;
   localparam logic [9:0]  IDX_CFG_BASE  = 10'h040;
   localparam logic [9:0]  IDX_BAD_LIMIT = 10'h0ff;
   localparam logic [9:0]  SEC_FIRST [SECTIONS] = '{10'h040, 10'h080, 10'h0c0};
   localparam logic [9:0]  SEC_LAST  [SECTIONS] = '{10'h059, 10'h0a3, 10'h0e3};
   //---------------------------------------------------------------------------
   // Field positions
   //---------------------------------------------------------------------------
   localparam int          PS_RESET      = 0;
   localparam int          PS_BADADDR    = 1;
   localparam int          PS_SUPPLY     = 2;
   localparam int          PS_CLOCK      = 3;
   localparam int          PS_DIGITAL    = 4;
   localparam int          DS_TRIM       = 3;
   localparam int          CTL_POLY      = 3;
   //---------------------------------------------------------------------------
   // Checksum
   //---------------------------------------------------------------------------
   localparam logic [15:0] POLY_CCITT    = 16'h1021;
   localparam logic [15:0] POLY_ANSI     = 16'h8005;
   localparam logic [15:0] CRC_SEED      = 16'hffff;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;

   function automatic logic [15:0] crc_bit(input logic [15:0] crc, input logic din,
                                           input logic [15:0] poly);
      crc_bit = {crc[14:0], 1'b0} ^ ((crc[15] ^ din) ? poly : 16'h0000);
   endfunction

   function automatic logic [15:0] crc_word(input logic [15:0] crc, input logic [15:0] w,
                                            input logic [15:0] poly);
      logic [15:0] c;
      c = crc;
      for (int i = 15; i >= 0; i--) begin
         c = crc_bit(c, w[i], poly);
      end
      crc_word = c;
   endfunction

   // Trim memory powers up all zero, so the production value is the checksum of zeros.
   function automatic logic [15:0] trim_reference();
      logic [15:0] c;
      c = CRC_SEED;
      for (int i = 0; i < TRIM_WORDS; i++) begin
         c = crc_word(c, 16'h0000, POLY_CCITT);
      end
      trim_reference = c;
   endfunction

   localparam logic [15:0] TRIM_REF      = trim_reference();
endpackage

/* core/cim_monitor.sv */
/*
  Configuration integrity monitor: register store, section checksums, trim memory
  checksum, pin readback, access monitor and status flags behind an AXI4-Lite slave.
  Assumes diag_osc, pin_level and the external fault inputs are asynchronous to aclk.
*/
`timescale 1ns/10ps
module cim_monitor #(
   parameter int PINS = 8
) (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic                       ce,
   input  wire logic [11:0]                s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [11:0]                s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       diag_osc,
   input  wire logic [PINS-1:0]            pin_level,
   input  wire logic [cim_pkg::FLAG_W-1:0] supply_fault_in_n,
   input  wire logic [cim_pkg::FLAG_W-1:0] clock_fault_in_n,
   output logic [15:0]                     status_word,
   output logic [PINS-1:0]                 pin_drive_enable,
   output logic [PINS-1:0]                 pin_drive_value
);
   import cim_pkg::*;

   if (PINS < 1 || PINS > 8) begin : g_bad_pins
      $error("PINS must lie between 1 and 8");
   end

   localparam int SYN_W = 1 + PINS + 2 * FLAG_W;
   // Reset to idle levels, so no false fault latches.
   localparam logic [SYN_W-1:0] SYN_IDLE = {{(2 * FLAG_W){1'b1}}, {(PINS + 1){1'b0}}};

   //---------------------------------------------------------------------------
   // Input synchronisers
   //---------------------------------------------------------------------------
   logic [SYN_W-1:0]  sync_a;
   logic [SYN_W-1:0]  sync_b;
   logic              osc_last;
   wire               osc_s    = sync_b[0];
   wire  [PINS-1:0]   pins_s   = sync_b[PINS:1];
   wire  [FLAG_W-1:0] supply_s = sync_b[PINS+FLAG_W:PINS+1];
   wire  [FLAG_W-1:0] clock_s  = sync_b[SYN_W-1:PINS+FLAG_W+1];
   wire               osc_tick = ce & osc_s & ~osc_last;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_a   <= SYN_IDLE;
         sync_b   <= SYN_IDLE;
         osc_last <= 1'b0;
      end else if (ce) begin
         sync_a   <= {clock_fault_in_n, supply_fault_in_n, pin_level, diag_osc};
         sync_b   <= sync_a;
         osc_last <= osc_s;
      end
   end

   //---------------------------------------------------------------------------
   // AXI4-Lite handshakes
   //---------------------------------------------------------------------------
   // Address and data may come in either order.
   logic              aw_held;
   logic              w_held;
   logic [IDX_W-1:0]  wr_idx;
   logic [15:0]       wr_data;
   logic [1:0]        wr_strb;
   wire               aw_take = ce & s_axi_awvalid & s_axi_awready;
   wire               w_take  = ce & s_axi_wvalid & s_axi_wready;
   wire               wr_go   = ce & aw_held & w_held & ~s_axi_bvalid;
   wire               ar_take = ce & s_axi_arvalid & s_axi_arready;
   wire  [IDX_W-1:0]  rd_idx  = s_axi_araddr[11:2];
   wire  [15:0]       wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         wr_idx        <= '0;
         wr_data       <= '0;
         wr_strb       <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
      end else if (ce) begin
         if (aw_take) begin
            aw_held       <= 1'b1;
            wr_idx        <= s_axi_awaddr[11:2];
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            w_held       <= 1'b1;
            wr_data      <= s_axi_wdata[15:0];
            wr_strb      <= s_axi_wstrb[1:0];
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   assign s_axi_bresp = RESP_OKAY;
   assign s_axi_rresp = RESP_OKAY;

   //---------------------------------------------------------------------------
   // Write decode
   //---------------------------------------------------------------------------
   wire              wr_cfg    = wr_go & (wr_idx >= IDX_CFG_BASE) & (wr_idx < IDX_BAD_LIMIT);
   wire              wr_trim   = wr_go & (wr_idx >= IDX_TRIM_BASE) &
                                 (wr_idx < IDX_TRIM_BASE + 10'(TRIM_WORDS));
   wire              wr_ctl    = wr_go & (wr_idx == IDX_CONTROL);
   wire              wr_gpio   = wr_go & (wr_idx == IDX_GPIO_CTL);
   wire              wr_exp    = wr_go & (wr_idx >= IDX_EXPECT) &
                                 (wr_idx < IDX_EXPECT + 10'(SECTIONS));
   wire [15:0]       clr_prim  = (wr_go & (wr_idx == IDX_PRIMARY)) ? wr_data & wr_mask : '0;
   wire [15:0]       clr_dig   = (wr_go & (wr_idx == IDX_DIGITAL)) ? wr_data & wr_mask : '0;
   wire [15:0]       clr_sup   = (wr_go & (wr_idx == IDX_SUPPLY)) ? wr_data & wr_mask : '0;
   wire [15:0]       clr_clk   = (wr_go & (wr_idx == IDX_CLOCK)) ? wr_data & wr_mask : '0;
   wire              bad_wr    = wr_go & (wr_idx >= IDX_BAD_LIMIT);
   wire              bad_rd    = ar_take & (rd_idx >= IDX_BAD_LIMIT);
   wire [7:0]        cfg_wsel  = 8'(wr_idx - IDX_CFG_BASE);
   wire [3:0]        trim_wsel = 4'(wr_idx - IDX_TRIM_BASE);
   wire [1:0]        exp_wsel  = 2'(wr_idx - IDX_EXPECT);

   //---------------------------------------------------------------------------
   // Configuration store, control and trim memory
   //---------------------------------------------------------------------------
   logic [15:0]      cfg_mem  [CFG_WORDS];
   logic [15:0]      trim_mem [TRIM_WORDS];
   logic [15:0]      expected [SECTIONS];
   logic [SECTIONS-1:0] sec_enable;
   logic             poly_ansi;
   logic [15:0]      gpio_ctl;
   wire  [15:0]      poly = poly_ansi ? POLY_ANSI : POLY_CCITT;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < CFG_WORDS; i++) cfg_mem[i] <= '0;
         for (int i = 0; i < TRIM_WORDS; i++) trim_mem[i] <= '0;
         for (int i = 0; i < SECTIONS; i++) expected[i] <= '0;
         sec_enable <= '0;
         poly_ansi  <= 1'b0;
         gpio_ctl   <= '0;
      end else if (ce) begin
         if (wr_cfg) cfg_mem[cfg_wsel] <= (cfg_mem[cfg_wsel] & ~wr_mask) | (wr_data & wr_mask);
         if (wr_trim) trim_mem[trim_wsel] <= (trim_mem[trim_wsel] & ~wr_mask) |
                                             (wr_data & wr_mask);
         if (wr_exp) expected[exp_wsel] <= (expected[exp_wsel] & ~wr_mask) |
                                           (wr_data & wr_mask);
         if (wr_ctl && wr_strb[0]) begin
            sec_enable <= wr_data[SECTIONS-1:0];
            poly_ansi  <= wr_data[CTL_POLY];
         end
         if (wr_gpio) gpio_ctl <= (gpio_ctl & ~wr_mask) | (wr_data & wr_mask);
      end
   end

   //---------------------------------------------------------------------------
   // Section checksum engines
   //---------------------------------------------------------------------------
   // Section zero has no engine: its bits follow device state and cannot be fixed.
   logic [SECTIONS-1:0] sec_fault_n;

   for (genvar s = 0; s < SECTIONS; s++) begin : g_sec
      localparam logic [9:0] BITS  = 10'((SEC_LAST[s] - SEC_FIRST[s] + 10'h001) << 4);
      localparam logic [7:0] BASE  = 8'(SEC_FIRST[s] - IDX_CFG_BASE);
      logic [15:0] crc;
      logic [9:0]  bit_cnt;
      wire  [7:0]  word_sel = BASE + 8'(bit_cnt[9:4]);
      wire  [3:0]  bit_sel  = 4'hf - bit_cnt[3:0];
      wire  [15:0] next_crc = crc_bit(crc, cfg_mem[word_sel][bit_sel], poly);
      wire         last     = (bit_cnt == BITS - 10'h001);
      wire         mismatch = sec_enable[s] & osc_tick & last & (next_crc != expected[s]);
      wire         clr      = clr_dig[s];

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            crc            <= CRC_SEED;
            bit_cnt        <= '0;
            sec_fault_n[s] <= 1'b1;
         end else if (ce) begin
            if (!sec_enable[s]) begin
               crc     <= CRC_SEED;
               bit_cnt <= '0;
            end else if (osc_tick) begin
               crc     <= last ? CRC_SEED : next_crc;
               bit_cnt <= last ? '0 : bit_cnt + 10'h001;
            end
            // A mismatch outranks a same-cycle clear.
            if (mismatch) sec_fault_n[s] <= 1'b0;
            else if (clr) sec_fault_n[s] <= 1'b1;
         end
      end
   end

   //---------------------------------------------------------------------------
   // Trim memory checksum, always running
   //---------------------------------------------------------------------------
   // This engine has no enable and never stops.
   logic [15:0] trim_crc;
   logic [3:0]  trim_idx;
   logic        trim_fault_n;
   wire  [15:0] next_trim_crc = crc_word(trim_crc, trim_mem[trim_idx], POLY_CCITT);
   wire         trim_last     = (trim_idx == 4'(TRIM_WORDS - 1));
   wire         trim_bad      = osc_tick & trim_last & (next_trim_crc != TRIM_REF);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trim_crc     <= CRC_SEED;
         trim_idx     <= '0;
         trim_fault_n <= 1'b1;
      end else if (ce) begin
         if (osc_tick) begin
            trim_crc <= trim_last ? CRC_SEED : next_trim_crc;
            trim_idx <= trim_last ? 4'h0 : trim_idx + 4'h1;
         end
         if (trim_bad) trim_fault_n <= 1'b0;
         else if (clr_dig[DS_TRIM]) trim_fault_n <= 1'b1;
      end
   end

   //---------------------------------------------------------------------------
   // Detailed and primary status
   //---------------------------------------------------------------------------
   // Combined flags are plain ANDs, never latched.
   logic [FLAG_W-1:0] supply_n;
   logic [FLAG_W-1:0] clock_n;
   logic              reset_occurred_indicator_n;
   logic              bad_address_fault_n;
   wire  [15:0]       digital_status = {12'h000, trim_fault_n, sec_fault_n};
   wire               digital_combined_fault_n = &{trim_fault_n, sec_fault_n};
   wire               supply_combined_fault_n  = &supply_n;
   wire               clock_combined_fault_n   = &clock_n;
   wire  [15:0]       primary = {11'h000, digital_combined_fault_n, clock_combined_fault_n,
                                 supply_combined_fault_n, bad_address_fault_n,
                                 reset_occurred_indicator_n};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         supply_n                   <= '1;
         clock_n                    <= '1;
         reset_occurred_indicator_n <= 1'b0;
         bad_address_fault_n        <= 1'b1;
         status_word                <= '0;
      end else if (ce) begin
         for (int i = 0; i < FLAG_W; i++) begin
            if (!supply_s[i]) supply_n[i] <= 1'b0;
            else if (clr_sup[i]) supply_n[i] <= 1'b1;
            if (!clock_s[i]) clock_n[i] <= 1'b0;
            else if (clr_clk[i]) clock_n[i] <= 1'b1;
         end
         if (clr_prim[PS_RESET]) reset_occurred_indicator_n <= 1'b1;
         if (bad_wr || bad_rd) bad_address_fault_n <= 1'b0;
         else if (clr_prim[PS_BADADDR]) bad_address_fault_n <= 1'b1;
         status_word <= primary;
      end
   end

   //---------------------------------------------------------------------------
   // Pins and readback
   //---------------------------------------------------------------------------
   // Each field is {configured as output, sensed level}; inputs read zero.
   // Readback trails a drive change by three cycles.
   logic [15:0] readback;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_drive_enable <= '0;
         pin_drive_value  <= '0;
         readback         <= '0;
      end else if (ce) begin
         pin_drive_enable <= gpio_ctl[PINS-1:0];
         pin_drive_value  <= gpio_ctl[PINS+7:8];
         for (int i = 0; i < PINS; i++) begin
            readback[2*i]   <= pin_drive_enable[i] & pins_s[i];
            readback[2*i+1] <= pin_drive_enable[i];
         end
      end
   end

   //---------------------------------------------------------------------------
   // Read decode
   //---------------------------------------------------------------------------
   // One read at a time keeps the reply simple.
   wire        rd_cfg   = (rd_idx >= IDX_CFG_BASE) & (rd_idx < IDX_BAD_LIMIT);
   wire        rd_trim  = (rd_idx >= IDX_TRIM_BASE) &
                          (rd_idx < IDX_TRIM_BASE + 10'(TRIM_WORDS));
   wire        rd_exp   = (rd_idx >= IDX_EXPECT) & (rd_idx < IDX_EXPECT + 10'(SECTIONS));
   wire [15:0] ctl_word = {12'h000, poly_ansi, sec_enable};
   wire        rd_known = rd_cfg | rd_trim | rd_exp | (rd_idx <= IDX_CONTROL) |
                          (rd_idx == IDX_GPIO_CTL) | (rd_idx == IDX_GPIO_RB);
   wire [15:0] rd_word  = rd_cfg                   ? cfg_mem[8'(rd_idx - IDX_CFG_BASE)] :
                          rd_trim                  ? trim_mem[4'(rd_idx - IDX_TRIM_BASE)] :
                          rd_exp                   ? expected[2'(rd_idx - IDX_EXPECT)] :
                          (rd_idx == IDX_PRIMARY)  ? primary :
                          (rd_idx == IDX_DIGITAL)  ? digital_status :
                          (rd_idx == IDX_SUPPLY)   ? {12'h000, supply_n} :
                          (rd_idx == IDX_CLOCK)    ? {12'h000, clock_n} :
                          (rd_idx == IDX_CONTROL)  ? ctl_word :
                          (rd_idx == IDX_GPIO_CTL) ? gpio_ctl :
                          (rd_idx == IDX_GPIO_RB)  ? readback : 16'h0000;
   // A nonexistent index answers zero in both the echo and the data.
   wire [31:0] rd_reply = rd_known ? {8'h00, rd_idx[7:0], rd_word} : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
      end else if (ce) begin
         if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_reply;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule

/* verification/cim_monitor_checker.sv */
/*
  Port-level checks of the configuration integrity monitor.
  Assumes it is bound to cim_monitor and that the bench keeps ce high.
*/
`timescale 1ns/10ps
module cim_monitor_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [15:0] status_word
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_bad_read_flags:
      assert property (s_axi_arvalid && s_axi_arready && ce && s_axi_araddr[11:2] >= 10'h0ff
         |-> ##[1:6] !status_word[1]) else $error("bad index did not raise access flag");
   chk_gap_read_quiet:
      assert property (s_axi_arvalid && s_axi_arready && ce && s_axi_araddr[11:2] == 10'h00a
         && status_word[1] |=> status_word[1] [*4]) else $error("undefined index raised flag");
   chk_bad_read_zero:
      assert property (s_axi_arvalid && s_axi_arready && ce && s_axi_araddr[11:2] >= 10'h0ff
         |=> s_axi_rdata == 32'h0) else $error("bad index read not zero");
   chk_flag_latched:
      assert property ($rose(status_word[1]) |-> $past(s_axi_bvalid) || !$past(aresetn, 2))
         else $error("access flag cleared without a write");
   chk_bvalid_holds:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
         else $error("write response dropped early");
   chk_rdata_holds:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
         else $error("read data dropped early");
   chk_write_busy:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
         else $error("write accepted while response pending");
   chk_read_busy:
      assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
endmodule
bind cim_monitor cim_monitor_checker i_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .status_word(status_word));

/* verification/cim_pin_model.sv */
/*
  Pads and diagnostic oscillator around the monitor.
  Assumes undriven pins sit on a pull-down.
*/
`timescale 1ns/10ps
module cim_pin_model #(
   parameter int PINS = 8
) (
   output logic            diag_osc,
   input  wire logic [PINS-1:0] drive_enable,
   input  wire logic [PINS-1:0] drive_value,
   output logic [PINS-1:0] level
);
   // Free running, but at a fixed phase to aclk: every edge falls 0.5 ns after an aclk rising edge.
   initial begin
      diag_osc = 1'b0;
      #3;
      forever #10 diag_osc = ~diag_osc;
   end
   assign level = drive_enable & drive_value;
endmodule

/* verification/cim_monitor_tb.sv */
/*
  Self-checking bench of the configuration integrity monitor over AXI4-Lite.
  Assumes a 200 MHz aclk and an oscillator period of four aclk cycles.
*/
`timescale 1ns/10ps
module cim_monitor_tb;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hs;
   logic        awready, wready, bvalid, arready, rvalid, osc;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [1:0]  bresp, rresp;
   logic [3:0]  sup_n;
   logic [15:0] status_word;
   logic [7:0]  lvl, pen, pval;
   int          n_errors, total_checks;
   cim_monitor i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .diag_osc(osc),
      .pin_level(lvl), .supply_fault_in_n(sup_n), .clock_fault_in_n(4'hf),
      .status_word(status_word), .pin_drive_enable(pen), .pin_drive_value(pval));
   cim_pin_model i_pins (.diag_osc(osc), .drive_enable(pen), .drive_value(pval), .level(lvl));
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, s);
         n_errors++;
      end
   endtask
   task automatic wr(input logic [9:0] i, input logic [15:0] d);
      @(posedge aclk);
      awaddr <= {i, 2'b00}; wdata <= {16'h0000, d}; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         hs = bvalid && bready;
         if (hs) bready <= 1'b0;
      end while (!hs);
   endtask
   task automatic rd(input logic [9:0] i);
      @(posedge aclk);
      araddr <= {i, 2'b00}; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         hs = rvalid && rready;
         if (hs) rv = rdata;
         if (hs) rready <= 1'b0;
      end while (!hs);
   endtask
   function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] w,
                                         input logic [15:0] p);
      for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? p : 16'h0000);
      return c;
   endfunction
   task automatic t_reset;
      rd(10'h000); chk("primary", rv, 32'h0000001e);
      chk("status word", {16'h0, status_word}, 32'h0000001e);
      rd(10'h001); chk("digital", rv, 32'h0001000f);
   endtask
   task automatic t_access;
      rd(10'h00a); chk("gap read", rv, 32'h0);
      wr(10'h00a, 16'hffff); repeat (4) @(posedge aclk);
      chk("gap flag", {31'h0, status_word[1]}, 32'h1);
      rd(10'h0ff); chk("bad read", rv, 32'h0);
      repeat (4) @(posedge aclk);
      chk("bad flag", {31'h0, status_word[1]}, 32'h0);
      wr(10'h000, 16'h0002); repeat (4) @(posedge aclk);
      chk("bad clear", {31'h0, status_word[1]}, 32'h1);
      sup_n <= 4'he; repeat (4) @(posedge aclk); sup_n <= 4'hf; repeat (4) @(posedge aclk);
      chk("supply comb", {31'h0, status_word[2]}, 32'h0);
      rd(10'h002); chk("supply detail", rv, 32'h0002000e);
      wr(10'h002, 16'h0001);
   endtask
   task automatic t_pins;
      wr(10'h008, 16'h5a0f); repeat (8) @(posedge aclk);
      rd(10'h009); chk("readback", rv, 32'h000900ee);
   endtask
   task automatic t_section;
      logic [15:0] c;
      for (int k = 0; k < 26; k++) wr(10'h040 + 10'(k), 16'ha5c3 ^ 16'(k));
      for (int q = 0; q < 2; q++) begin
         c = 16'hffff;
         for (int k = 0; k < 26; k++) c = crc16(c, 16'ha5c3 ^ 16'(k), q ? 16'h8005 : 16'h1021);
         wr(10'h004, 16'h0000); wr(10'h001, 16'h0007); wr(10'h005, c);
         wr(10'h004, 16'(q * 8 + 1)); repeat (3500) @(posedge aclk);
         rd(10'h001); chk("match", rv, 32'h0001000f);
         wr(10'h005, c ^ 16'h0001); repeat (3500) @(posedge aclk);
         rd(10'h001); chk("mismatch", rv, 32'h0001000e);
         chk("digital comb", {31'h0, status_word[4]}, 32'h0);
         wr(10'h005, c); repeat (3500) @(posedge aclk);
         rd(10'h001); chk("latched", rv, 32'h0001000e);
         wr(10'h001, 16'h0001); rd(10'h001); chk("cleared", rv, 32'h0001000f);
      end
   endtask
   task automatic t_trim;
      wr(10'h020, 16'h0001); repeat (150) @(posedge aclk);
      rd(10'h001); chk("trim fault", rv, 32'h00010007);
      wr(10'h001, 16'h0008); repeat (150) @(posedge aclk);
      rd(10'h001); chk("trim again", rv, 32'h00010007);
      aresetn <= 1'b0; repeat (3) @(posedge aclk); aresetn <= 1'b1;
      repeat (150) @(posedge aclk); rd(10'h001); chk("trim reset", rv, 32'h0001000f);
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
      {awaddr, araddr, wdata} = '0; sup_n = 4'hf; n_errors = 0; total_checks = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset(); t_access(); t_pins(); t_section(); t_trim();
      print_verdict();
   end
   initial begin
      repeat (60000) @(posedge aclk);
      n_errors++;
      print_verdict();
   end
endmodule
